// *** core/pss_evcnt.sv ***
// Saturating event counter that clears when it is read.
`timescale 1ns/100ps
module pss_evcnt #(
  parameter int WIDTH = 16
) (
  // Clock and reset.
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Event, clearing read and count.
  input  wire logic             evt,
  input  wire logic             clr,
  output logic [WIDTH-1:0]      count
);

  localparam logic [WIDTH-1:0] ONE = WIDTH'(1);
  localparam logic [WIDTH-1:0] ZERO = WIDTH'(0);

  logic             full;
  logic [WIDTH-1:0] next_count;

  assign full = &count;
  // An event in the reading cycle starts the fresh count instead of being lost.
  assign next_count = clr ? (evt ? ONE : ZERO) : ((evt && !full) ? count + ONE : count);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= ZERO;
    end else begin
      count <= next_count;
    end
  end

endmodule

// *** core/pss_latch.sv ***
// Single status latch, either latched-high or latched-low, cleared by a read strobe.
`timescale 1ns/100ps
module pss_latch #(
  parameter bit LATCH_LOW = 1'b0
) (
  // Clock and reset.
  input  wire logic pclk,
  input  wire logic presetn,
  // Condition, clearing read and latched view.
  input  wire logic cond,
  input  wire logic clr,
  output logic      q
);

  logic held;
  logic hit;
  logic next_held;

  // A latched-low bit starts as lost, so it reads zero until its first read.
  localparam bit HELD_RESET = LATCH_LOW;

  assign hit = LATCH_LOW ? ~cond : cond;
  // The event wins over a clearing read in the same cycle.
  assign next_held = hit | (held & ~clr);
  assign q = LATCH_LOW ? (cond & ~held) : held;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      held <= HELD_RESET;
    end else begin
      held <= next_held;
    end
  end

endmodule

// *** core/pss_pkg.sv ***
// Package with the register map, field positions and carrier types of the status summary block.
package pss_pkg;

  // Register indices; the byte address of each register is four times its index.
  localparam logic [7:0] IDX_BASIC_STATUS = 8'h01;
  localparam logic [7:0] IDX_NEG_EXPANSION = 8'h06;
  localparam logic [7:0] IDX_SUMMARY = 8'h10;
  localparam logic [7:0] IDX_FALSE_CARRIER_CNT = 8'h14;
  localparam logic [7:0] IDX_RECEIVE_ERROR_CNT = 8'h15;
  localparam logic [7:0] IDX_TEN_MBIT_STATUS = 8'h1A;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h20;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h21;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int SUM_W = 16;
  localparam int CNT_W = 16;
  localparam int IRQ_W = 8;

  // Summary register field positions.
  localparam int SUM_RSVD_HI = 15;
  localparam int SUM_RSVD_LO = 14;
  localparam int SUM_RX_ERR = 13;
  localparam int SUM_POLARITY = 12;
  localparam int SUM_FALSE_CARRIER = 11;
  localparam int SUM_SIGNAL_DETECT = 10;
  localparam int SUM_DESCR_LOCK = 9;
  localparam int SUM_PAGE_RX = 8;
  localparam int SUM_RSVD_7 = 7;
  localparam int SUM_REMOTE_FAULT = 6;
  localparam int SUM_JABBER = 5;
  localparam int SUM_AN_DONE = 4;
  localparam int SUM_LOOPBACK = 3;
  localparam int SUM_DUPLEX = 2;
  localparam int SUM_SPEED = 1;
  localparam int SUM_RSVD_0 = 0;

  // Positions inside the neighbouring source registers.
  localparam int TEN_POLARITY = 4;
  localparam int EXP_PAGE_RX = 1;
  localparam int BAS_REMOTE_FAULT = 4;
  localparam int BAS_JABBER = 1;

  // Interrupt status and mask bit positions.
  localparam int IRQ_RX_ERR = 0;
  localparam int IRQ_FALSE_CARRIER = 1;
  localparam int IRQ_PAGE_RX = 2;
  localparam int IRQ_REMOTE_FAULT = 3;
  localparam int IRQ_JABBER = 4;
  localparam int IRQ_SIGNAL_LOST = 5;
  localparam int IRQ_LOCK_LOST = 6;
  localparam int IRQ_AN_DONE = 7;

  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 8'h00;
  localparam logic [DATA_W-1:0] RDATA_RESET = 32'h0000_0000;

  // Live conditions and event pulses from the transceiver core.
  typedef struct packed {
    logic rx_error_evt;
    logic false_carrier_evt;
    logic polarity_inverted;
    logic signal_detect;
    logic descr_lock;
    logic page_rx_evt;
    logic remote_fault_evt;
    logic jabber_evt;
    logic an_complete;
    logic an_enable;
    logic loopback_en;
    logic full_duplex;
    logic link_valid;
    logic low_speed_flag;
  } pss_phy_in_t;

endpackage

// *** core/pss_summary.sv ***
// Status summary register bank with its source latches, counters and APB slave.
// Operation
// - Bits 15 and 14 are reserved: writes ignored, read as zero.
// - Bit 13 latches on receive error until the receive error counter is read.
// - Bit 12 mirrors inverted polarity; cleared by ten Mbit status register read only, not by a summary read.
// - Bit 11 latches on false carrier until the false carrier counter is read.
// - Bit 10 shows 100 Mb/s signal detect as latched-low, default zero.
// - Bit 9 shows 100 Mb/s descrambler lock as latched-low, default zero.
// - Bit 8 copies page received; cleared by expansion register read only.
// - Remote fault sets from the partner; cleared by basic status read or reset.
// - Bit 5 copies jabber detect; a summary read does not clear it.
// - Bit 4 shows negotiation complete, read-only, default zero.
// - Bit 3 shows loopback enabled, read-only, default zero.
// - Bit 2 shows full duplex, only with valid link and, while negotiation is enabled, finished negotiation.
// - Bit 1 shows the current speed status, read-only, default zero.
// - Bit 7 is reserved: writes ignored, read as zero.
//
// Implementation choice: register access over APB.
`timescale 1ns/100ps
module pss_summary (
  // Clock and reset.
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  // APB slave.
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [pss_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [pss_pkg::DATA_W-1:0]  pwdata,
  input  wire logic [3:0]                  pstrb,
  output logic [pss_pkg::DATA_W-1:0]       prdata,
  output logic                             pready,
  output logic                             pslverr,
  // Transceiver conditions and events.
  input  wire pss_pkg::pss_phy_in_t        phy_in,
  // Interrupt.
  output logic                             irq
);

  function automatic logic at_idx(input logic [pss_pkg::ADDR_W-1:0] addr, input logic [7:0] idx);
    at_idx = (addr == {2'b00, idx, 2'b00});
  endfunction

  // Bus decode. Side effects and data capture share the setup edge, so nothing is lost between them.
  logic setup;
  logic rd_take;
  logic wr_take;
  logic hit_summary;
  logic hit_basic;
  logic hit_exp;
  logic hit_fc;
  logic hit_rxe;
  logic hit_ten;
  logic hit_ist;
  logic hit_imask;
  logic mapped;

  assign setup = psel & ~penable;
  assign rd_take = setup & ~pwrite;
  assign wr_take = setup & pwrite;
  assign hit_summary = at_idx(paddr, pss_pkg::IDX_SUMMARY);
  assign hit_basic = at_idx(paddr, pss_pkg::IDX_BASIC_STATUS);
  assign hit_exp = at_idx(paddr, pss_pkg::IDX_NEG_EXPANSION);
  assign hit_fc = at_idx(paddr, pss_pkg::IDX_FALSE_CARRIER_CNT);
  assign hit_rxe = at_idx(paddr, pss_pkg::IDX_RECEIVE_ERROR_CNT);
  assign hit_ten = at_idx(paddr, pss_pkg::IDX_TEN_MBIT_STATUS);
  assign hit_ist = at_idx(paddr, pss_pkg::IDX_IRQ_STATUS);
  assign hit_imask = at_idx(paddr, pss_pkg::IDX_IRQ_MASK);
  assign mapped = hit_summary | hit_basic | hit_exp | hit_fc | hit_rxe | hit_ten | hit_ist | hit_imask;

  logic rd_summary;
  logic rd_basic;
  logic rd_exp;
  logic rd_fc;
  logic rd_rxe;
  logic rd_ten;
  logic rd_ist;
  logic wr_imask;

  assign rd_summary = rd_take & hit_summary;
  assign rd_basic = rd_take & hit_basic;
  assign rd_exp = rd_take & hit_exp;
  assign rd_fc = rd_take & hit_fc;
  assign rd_rxe = rd_take & hit_rxe;
  assign rd_ten = rd_take & hit_ten;
  assign rd_ist = rd_take & hit_ist;
  assign wr_imask = wr_take & hit_imask & pstrb[0];

  // Source latches.
  logic rx_err_q;
  logic fc_q;
  logic pol_q;
  logic sd_q;
  logic lock_q;
  logic page_q;
  logic rf_q;
  logic jab_q;

  pss_latch #(.LATCH_LOW(1'b0)) u_rx_err (
    .pclk    (pclk),
    .presetn (presetn),
    .cond    (phy_in.rx_error_evt),
    .clr     (rd_rxe),
    .q       (rx_err_q)
  );

  pss_latch #(.LATCH_LOW(1'b0)) u_fc (
    .pclk    (pclk),
    .presetn (presetn),
    .cond    (phy_in.false_carrier_evt),
    .clr     (rd_fc),
    .q       (fc_q)
  );

  pss_latch #(.LATCH_LOW(1'b0)) u_pol (
    .pclk    (pclk),
    .presetn (presetn),
    .cond    (phy_in.polarity_inverted),
    .clr     (rd_ten),
    .q       (pol_q)
  );

  pss_latch #(.LATCH_LOW(1'b1)) u_sd (
    .pclk    (pclk),
    .presetn (presetn),
    .cond    (phy_in.signal_detect),
    .clr     (rd_summary),
    .q       (sd_q)
  );

  pss_latch #(.LATCH_LOW(1'b1)) u_lock (
    .pclk    (pclk),
    .presetn (presetn),
    .cond    (phy_in.descr_lock),
    .clr     (rd_summary),
    .q       (lock_q)
  );

  pss_latch #(.LATCH_LOW(1'b0)) u_page (
    .pclk    (pclk),
    .presetn (presetn),
    .cond    (phy_in.page_rx_evt),
    .clr     (rd_exp),
    .q       (page_q)
  );

  pss_latch #(.LATCH_LOW(1'b0)) u_rf (
    .pclk    (pclk),
    .presetn (presetn),
    .cond    (phy_in.remote_fault_evt),
    .clr     (rd_basic),
    .q       (rf_q)
  );

  pss_latch #(.LATCH_LOW(1'b0)) u_jab (
    .pclk    (pclk),
    .presetn (presetn),
    .cond    (phy_in.jabber_evt),
    .clr     (rd_basic),
    .q       (jab_q)
  );

  // Event counters behind the receive error and false carrier latches.
  logic [pss_pkg::CNT_W-1:0] rxe_count;
  logic [pss_pkg::CNT_W-1:0] fc_count;

  pss_evcnt #(.WIDTH(pss_pkg::CNT_W)) u_rxe_cnt (
    .pclk    (pclk),
    .presetn (presetn),
    .evt     (phy_in.rx_error_evt),
    .clr     (rd_rxe),
    .count   (rxe_count)
  );

  pss_evcnt #(.WIDTH(pss_pkg::CNT_W)) u_fc_cnt (
    .pclk    (pclk),
    .presetn (presetn),
    .evt     (phy_in.false_carrier_evt),
    .clr     (rd_fc),
    .count   (fc_count)
  );

  // Summary word. Duplex is forced to half while it carries no meaning.
  logic                      duplex_valid;
  logic [pss_pkg::SUM_W-1:0] summary_word;

  assign duplex_valid = phy_in.link_valid & (~phy_in.an_enable | phy_in.an_complete);
  assign summary_word[pss_pkg::SUM_RSVD_HI:pss_pkg::SUM_RSVD_LO] = 2'b00;
  assign summary_word[pss_pkg::SUM_RX_ERR] = rx_err_q;
  assign summary_word[pss_pkg::SUM_POLARITY] = pol_q;
  assign summary_word[pss_pkg::SUM_FALSE_CARRIER] = fc_q;
  assign summary_word[pss_pkg::SUM_SIGNAL_DETECT] = sd_q;
  assign summary_word[pss_pkg::SUM_DESCR_LOCK] = lock_q;
  assign summary_word[pss_pkg::SUM_PAGE_RX] = page_q;
  assign summary_word[pss_pkg::SUM_RSVD_7] = 1'b0;
  assign summary_word[pss_pkg::SUM_REMOTE_FAULT] = rf_q;
  assign summary_word[pss_pkg::SUM_JABBER] = jab_q;
  assign summary_word[pss_pkg::SUM_AN_DONE] = phy_in.an_complete;
  assign summary_word[pss_pkg::SUM_LOOPBACK] = phy_in.loopback_en;
  assign summary_word[pss_pkg::SUM_DUPLEX] = phy_in.full_duplex & duplex_valid;
  assign summary_word[pss_pkg::SUM_SPEED] = phy_in.low_speed_flag;
  assign summary_word[pss_pkg::SUM_RSVD_0] = 1'b0;

  // Interrupt status and mask.
  logic                      sd_prev;
  logic                      lock_prev;
  logic                      an_prev;
  logic [pss_pkg::IRQ_W-1:0] irq_events;
  logic [pss_pkg::IRQ_W-1:0] irq_status;
  logic [pss_pkg::IRQ_W-1:0] irq_mask;
  logic [pss_pkg::IRQ_W-1:0] next_irq_status;
  logic [pss_pkg::IRQ_W-1:0] next_irq_mask;

  assign irq_events[pss_pkg::IRQ_RX_ERR] = phy_in.rx_error_evt;
  assign irq_events[pss_pkg::IRQ_FALSE_CARRIER] = phy_in.false_carrier_evt;
  assign irq_events[pss_pkg::IRQ_PAGE_RX] = phy_in.page_rx_evt;
  assign irq_events[pss_pkg::IRQ_REMOTE_FAULT] = phy_in.remote_fault_evt;
  assign irq_events[pss_pkg::IRQ_JABBER] = phy_in.jabber_evt;
  assign irq_events[pss_pkg::IRQ_SIGNAL_LOST] = sd_prev & ~phy_in.signal_detect;
  assign irq_events[pss_pkg::IRQ_LOCK_LOST] = lock_prev & ~phy_in.descr_lock;
  assign irq_events[pss_pkg::IRQ_AN_DONE] = ~an_prev & phy_in.an_complete;
  // A new event in the reading cycle stays pending for the next read.
  assign next_irq_status = irq_events | (rd_ist ? '0 : irq_status);
  assign next_irq_mask = wr_imask ? pwdata[pss_pkg::IRQ_W-1:0] : irq_mask;

  // Read multiplexer; unmapped reads return zero.
  logic [pss_pkg::DATA_W-1:0] rd_word;

  assign rd_word = hit_summary ? {16'h0000, summary_word} :
                   hit_rxe     ? {16'h0000, rxe_count} :
                   hit_fc      ? {16'h0000, fc_count} :
                   hit_ten     ? {27'h0000000, pol_q, 4'h0} :
                   hit_exp     ? {30'h00000000, page_q, 1'b0} :
                   hit_basic   ? {27'h0000000, rf_q, 2'b00, jab_q, 1'b0} :
                   hit_ist     ? {24'h000000, irq_status} :
                   hit_imask   ? {24'h000000, irq_mask} :
                   pss_pkg::RDATA_RESET;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sd_prev    <= 1'b0;
      lock_prev  <= 1'b0;
      an_prev    <= 1'b0;
      irq_status <= '0;
      irq_mask   <= pss_pkg::IRQ_MASK_RESET;
      irq        <= 1'b0;
    end else begin
      sd_prev    <= phy_in.signal_detect;
      lock_prev  <= phy_in.descr_lock;
      an_prev    <= phy_in.an_complete;
      irq_status <= next_irq_status;
      irq_mask   <= next_irq_mask;
      irq        <= |(next_irq_status & next_irq_mask);
    end
  end

  // One wait-free access phase: the answer is ready in the first cycle with penable high.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= pss_pkg::RDATA_RESET;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~mapped;
      if (rd_take) begin
        prdata <= rd_word;
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_RSVD_HI_ZERO: assert property (rd_summary |=> prdata[15:14] == 2'b00)
    else $error("Reserved bits 15:14 read nonzero.");
  AST_RSVD7_ZERO: assert property (rd_summary |=> prdata[7] == 1'b0)
    else $error("Reserved bit 7 read nonzero.");
  AST_RXERR_LATCH: assert property (phy_in.rx_error_evt ##1 (!rd_rxe)[*2] |=> summary_word[13])
    else $error("Receive error latch did not hold.");
  AST_RXERR_CLEAR: assert property ((rd_rxe && !phy_in.rx_error_evt) |=> !summary_word[13])
    else $error("Receive error latch not cleared by counter read.");
  AST_POL_KEEP: assert property ((pol_q && rd_summary && !rd_ten) |=> pol_q)
    else $error("Polarity bit cleared by summary read.");
  AST_FC_LATCH: assert property ((phy_in.false_carrier_evt && !rd_fc) |=> fc_q && fc_count != 16'h0000)
    else $error("False carrier latch or count missing.");
  AST_SD_LOW: assert property ((!phy_in.signal_detect ##1 !rd_summary) |=> !summary_word[10])
    else $error("Signal detect loss not held low.");
  AST_LOCK_LOW: assert property (!phy_in.descr_lock |=> !summary_word[9])
    else $error("Descrambler lock loss not held low.");
  AST_PAGE_KEEP: assert property ((page_q && !rd_exp) |=> page_q)
    else $error("Page received cleared without expansion read.");
  AST_RF_CLEAR: assert property ((rd_basic && !phy_in.remote_fault_evt) |=> !rf_q)
    else $error("Remote fault not cleared by basic status read.");
  AST_JAB_KEEP: assert property ((jab_q && rd_summary && !rd_basic) |=> jab_q)
    else $error("Jabber cleared by summary read.");
  AST_AN_BIT: assert property (rd_summary |=> prdata[4] == $past(phy_in.an_complete))
    else $error("Negotiation complete bit wrong.");
  AST_LOOP_BIT: assert property (rd_summary |=> prdata[3] == $past(phy_in.loopback_en))
    else $error("Loopback bit wrong.");
  AST_DUPLEX_VALID: assert property ((rd_summary && !phy_in.link_valid) |=> !prdata[2])
    else $error("Duplex reported without valid link.");
  AST_SPEED_BIT: assert property (rd_summary |=> prdata[1] == $past(phy_in.low_speed_flag))
    else $error("Speed bit wrong.");
  AST_APB_READY: assert property (setup |=> pready ##1 !pready)
    else $error("Access phase not answered in one cycle.");
  AST_IRQ_LEVEL: assert property (irq == |(irq_status & irq_mask))
    else $error("Interrupt level disagrees with status and mask.");

endmodule

// *** sim/phy_status_summary_register_test.sv ***
// Self-checking testbench of the status summary register bank, driven over APB.
`timescale 1ns/100ps
module phy_status_summary_register_test;
  localparam logic [13:0] M_RXERR = 14'h2000;
  localparam logic [13:0] M_FC    = 14'h1000;
  localparam logic [13:0] M_POL   = 14'h0800;
  localparam logic [13:0] M_SD    = 14'h0400;
  localparam logic [13:0] M_LOCK  = 14'h0200;
  localparam logic [13:0] M_PAGE  = 14'h0100;
  localparam logic [13:0] M_RF    = 14'h0080;
  localparam logic [13:0] M_JAB   = 14'h0040;

  logic                       pclk;
  logic                       presetn;
  logic                       psel;
  logic                       penable;
  logic                       pwrite;
  logic [pss_pkg::ADDR_W-1:0] paddr;
  logic [pss_pkg::DATA_W-1:0] pwdata;
  logic [3:0]                 pstrb;
  logic [pss_pkg::DATA_W-1:0] prdata;
  logic                       pready;
  logic                       pslverr;
  logic [13:0]                phy;
  logic                       irq;
  int                         failures;
  int                         n_tests;
  logic [31:0]                rd;
  logic                       err;
  logic [31:0]                exp;

  // Event table: stimulus mask, summary bit, clearing register, its read value, expected interrupt status.
  logic [13:0]                ev_m [6];
  int                         ev_b [6];
  logic [7:0]                 ev_a [6];
  logic [31:0]                ev_v [6];
  logic [31:0]                ev_q [6];

  pss_summary dut (
    .pclk    (pclk),
    .presetn (presetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .pstrb   (pstrb),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .phy_in  (pss_pkg::pss_phy_in_t'(phy)),
    .irq     (irq)
  );

  initial pclk = 1'b0;
  always #2.5 pclk = ~pclk;

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] expv);
    n_tests++;
    if (seen !== expv) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, expv, seen);
    end
  endtask

  task automatic finish_test();
    if (failures == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Entered right after a rising edge; returns one idle cycle after the edge at which pready was seen high.
  // The idle edge keeps two back-to-back calls from assigning psel twice in one time step.
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 16) begin
      n++;
      @(posedge pclk);
    end
    if (n == 16) begin
      check("pready", pready, 32'h1);
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rdsum();
    apb(1'b0, pss_pkg::IDX_SUMMARY, 32'h0);
    check("summary error", err, 32'h0);
    check("summary reserved", rd & 32'hFFFF_C081, 32'h0);
  endtask

  // Flips the selected inputs for one cycle, which is one event pulse or one short loss of a level.
  task automatic toggle(input logic [13:0] m);
    phy <= phy ^ m;
    @(posedge pclk);
    phy <= phy ^ m;
    @(posedge pclk);
  endtask

  initial begin
    #50000;
    failures++;
    finish_test();
  end

  initial begin
    ev_m = '{M_RXERR, M_POL, M_FC, M_PAGE, M_RF, M_JAB};
    ev_b = '{pss_pkg::SUM_RX_ERR, pss_pkg::SUM_POLARITY, pss_pkg::SUM_FALSE_CARRIER,
             pss_pkg::SUM_PAGE_RX, pss_pkg::SUM_REMOTE_FAULT, pss_pkg::SUM_JABBER};
    ev_a = '{pss_pkg::IDX_RECEIVE_ERROR_CNT, pss_pkg::IDX_TEN_MBIT_STATUS, pss_pkg::IDX_FALSE_CARRIER_CNT,
             pss_pkg::IDX_NEG_EXPANSION, pss_pkg::IDX_BASIC_STATUS, pss_pkg::IDX_BASIC_STATUS};
    ev_v = '{32'h1, 32'h10, 32'h1, 32'h2, 32'h10, 32'h2};
    ev_q = '{32'h01, 32'h00, 32'h02, 32'h04, 32'h08, 32'h10};
    failures = 0;
    n_tests = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'hF;
    phy = M_SD | M_LOCK;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check("irq after reset", irq, 32'h0);
    rdsum();
    check("summary after reset", rd, 32'h0);
    rdsum();
    check("detect and lock", rd & 32'h600, 32'h600);
    toggle(M_SD);
    rdsum();
    check("signal loss held", rd & 32'h600, 32'h200);
    rdsum();
    check("signal back", rd & 32'h600, 32'h600);
    toggle(M_LOCK);
    rdsum();
    check("lock loss held", rd & 32'h600, 32'h400);
    rdsum();
    check("lock back", rd & 32'h600, 32'h600);
    // Every mix of negotiation, loopback, duplex, link and speed levels.
    for (int i = 0; i < 64; i++) begin
      phy[5:0] <= 6'(i);
      @(posedge pclk);
      rdsum();
      exp = {27'h0, i[5], i[3], i[2] & i[1] & (!i[4] | i[5]), i[0], 1'b0};
      check("live bits", rd & 32'h1E, exp);
    end
    apb(1'b1, pss_pkg::IDX_IRQ_MASK, 32'h0000_00FF);
    apb(1'b0, pss_pkg::IDX_IRQ_MASK, 32'h0);
    check("mask readback", rd, 32'h0000_00FF);
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, pss_pkg::IDX_IRQ_STATUS, 32'h0);
      toggle(ev_m[i]);
      check("irq raised", irq, 32'(ev_q[i] != 0));
      rdsum();
      check("event bit set", rd[ev_b[i]], 32'h1);
      rdsum();
      check("event bit kept", rd[ev_b[i]], 32'h1);
      apb(1'b0, pss_pkg::IDX_IRQ_STATUS, 32'h0);
      check("irq status", rd, ev_q[i]);
      check("irq after status read", irq, 32'h0);
      apb(1'b0, ev_a[i], 32'h0);
      // The polarity register returns the latched polarity bit, so it is judged like the others.
      check("source register", rd, ev_v[i]);
      rdsum();
      check("event bit cleared", rd[ev_b[i]], 32'h0);
    end
    apb(1'b1, pss_pkg::IDX_IRQ_MASK, 32'h0000_00FE);
    toggle(M_RXERR);
    check("masked irq", irq, 32'h0);
    apb(1'b0, pss_pkg::IDX_IRQ_STATUS, 32'h0);
    check("masked status", rd, 32'h1);
    toggle(M_RXERR);
    apb(1'b0, pss_pkg::IDX_RECEIVE_ERROR_CNT, 32'h0);
    check("error count", rd, 32'h2);
    rdsum();
    exp = rd;
    apb(1'b1, pss_pkg::IDX_SUMMARY, 32'hFFFF_FFFF);
    check("summary write error", err, 32'h0);
    rdsum();
    check("summary write ignored", rd, exp);
    check("summary live value", exp, 32'h0000_061E);
    apb(1'b0, 8'h3F, 32'h0);
    check("unmapped error", err, 32'h1);
    check("unmapped data", rd, 32'h0);
    finish_test();
  end
endmodule
